// >>> sep_consts.svh
/*
  Constants of the event interrupt pulser: register byte offsets, field
  positions, reset values and timing counts.
  Assumes a 40 MHz clock; every count below is derived from that rate.
*/
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH

`define SEP_CLK_MHZ          40
`define SEP_PULSE_US         100
`define SEP_GAP_US           100
`define SEP_CFG_FILT_US      10
`define SEP_PULSE_CYC        (`SEP_PULSE_US * `SEP_CLK_MHZ)
`define SEP_GAP_CYC          (`SEP_GAP_US * `SEP_CLK_MHZ)
`define SEP_CFG_FILT_CYC     (`SEP_CFG_FILT_US * `SEP_CLK_MHZ)
`define SEP_TMR_W            13

`define SEP_OFF_CTRL         8'h00
`define SEP_OFF_WAKE_A       8'h04
`define SEP_OFF_WAKE_B       8'h08
`define SEP_OFF_FAIL         8'h0C
`define SEP_OFF_SAFE         8'h10
`define SEP_OFF_MODE         8'h14
`define SEP_OFF_IRQ_STAT     8'h18
`define SEP_OFF_IRQ_MASK     8'h1C

`define SEP_CTRL_GLOBAL      0
`define SEP_CTRL_BUS_EN      1
`define SEP_CTRL_HV_EN       2
`define SEP_CTRL_TMR_EN      3
`define SEP_CTRL_GPIO_WAKE   4
`define SEP_CTRL_TO_MASK     5
`define SEP_CTRL_RST         6'h0E

`define SEP_WA_BUS_WAKE      0
`define SEP_WA_BUS_TO        1
`define SEP_WA_HV_WAKE       2
`define SEP_WA_TMR_WAKE      3

`define SEP_IS_PULSE         0
`define SEP_IS_STOP          1
`define SEP_IS_SAFE          2
`define SEP_IRQ_MASK_RST     3'h0

`endif

// >>> sep_pkg.sv
/*
  Types of the event interrupt pulser: operating modes and pulser states.
  Assumes the mode code is driven by the chip's mode controller.
*/
package sep_pkg;
  typedef enum logic [2:0]
  {
    SEP_MODE_INIT     = 3'h0,
    SEP_MODE_NORMAL   = 3'h1,
    SEP_MODE_STOP     = 3'h2,
    SEP_MODE_SLEEP    = 3'h3,
    SEP_MODE_RESTART  = 3'h4,
    SEP_MODE_FAILSAFE = 3'h5
  } sep_mode_t;

  typedef enum logic [1:0]
  {
    SEP_ST_IDLE  = 2'h0,
    SEP_ST_PULSE = 2'h1,
    SEP_ST_GAP   = 2'h2
  } sep_state_t;
endpackage

// >>> sep_sync.sv
/*
  Three-stage input synchroniser with agreement check.
  Assumes an asynchronous pin; the output moves only when stages two and
  three agree, so a single metastable sample is never passed on.
*/
module sep_sync
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      q
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        q <= s3_reg;
    end
  end
endmodule

// >>> sep_timer.sv
/*
  Loadable down counter; done is high while the count stands at zero.
  Assumes the load value fits the width.
*/
module sep_timer
#(
  parameter int W = 13
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt_reg;

  assign done = (cnt_reg == '0);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_reg <= '0;
    else if (load)
      cnt_reg <= load_val;
    else if (!done)
      cnt_reg <= cnt_reg - 1'b1;
  end
endmodule

// >>> sep_event_interrupt_pulser.sv
/*
  Event interrupt pulser: turns stored wake and failure events into fixed
  active-low pulses on the interrupt pin, with an Avalon-MM register file.
  Assumes event inputs come from logic on clk, the mode code from the mode
  controller on clk, and the pin readback from the pad (asynchronous).
*/
// Design decisions made here: the register addresses and the Avalon-MM register port.
// Functional notes
// - In normal and stop modes each interrupt drives the pin low 100 us.
// - Between pulses the pin stays high at least 100 us.
// - An interrupt never changes the operating mode by itself.
// - Class bit: 0 means wake-only interrupts, 1 adds failure interrupts.
// - A wake event interrupts only when its source is enabled.
// - Bus timeout interrupts follow only its own mask, not the class bit.
// - Wake sources: bus wake or timeout, wake pin, timer, wake-configured GPIO.
// - Global class adds failures; level and identity registers never interrupt.
// - Restart or fail-safe errors, power-on and mode bits never pulse the pin.
// - Pin stays inactive in restart, fail-safe and sleep modes.
// - Entering stop with any wake status bit set issues an interrupt.
// - Pending events reach status registers at each pulse falling edge.
// - Events stay latched until software clears them; level is not latched.
// - In init mode the pin is sampled through a 10 us select filter.
`include "sep_consts.svh"

module sep_event_interrupt_pulser
  import sep_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [2:0]  op_mode,
  input  wire logic        ev_bus_wake,
  input  wire logic        bus_timeout_flag,
  input  wire logic        ev_hv_wake,
  input  wire logic        ev_timer_wake,
  input  wire logic        ev_gpio_wake,
  input  wire logic [7:0]  ev_fail,
  input  wire logic [6:0]  ev_safe,
  input  wire logic [2:0]  wake_level_status,
  input  wire logic        irq_pin_in,
  output logic             irq_out_n,
  output logic             irq_oe,
  output logic             hw_cfg_sel,
  output logic             cpu_irq
);
  sep_state_t  state_reg;
  sep_state_t  state_next;
  logic [5:0]  ctrl_reg;
  logic [3:0]  wake_a_reg;
  logic        wake_b_reg;
  logic [7:0]  fail_reg;
  logic [6:0]  safe_reg;
  logic [2:0]  irq_stat_reg;
  logic [2:0]  irq_mask_reg;
  logic [3:0]  pend_a_reg;
  logic        pend_b_reg;
  logic [7:0]  pend_f_reg;
  logic        stop_req_reg;
  logic [2:0]  mode_prev_reg;
  logic        cfg_cand_reg;
  logic        cfg_valid_reg;
  logic        irq_out_n_reg;
  logic        irq_oe_reg;
  logic        hw_cfg_reg;
  logic        cpu_irq_reg;
  logic [31:0] rdata_reg;
  logic        wait_reg;

  // Bus decode. Only byte lane 0 carries writable fields.
  wire req        = avs_read | avs_write;
  wire acc        = req & ~wait_reg;
  wire wr_lane    = avs_write & acc & avs_byteenable[0];
  wire [7:0] wd   = avs_writedata[7:0];
  wire hit_ctrl   = (avs_address == `SEP_OFF_CTRL);
  wire hit_wa     = (avs_address == `SEP_OFF_WAKE_A);
  wire hit_wb     = (avs_address == `SEP_OFF_WAKE_B);
  wire hit_fail   = (avs_address == `SEP_OFF_FAIL);
  wire hit_safe   = (avs_address == `SEP_OFF_SAFE);
  wire hit_mode   = (avs_address == `SEP_OFF_MODE);
  wire hit_istat  = (avs_address == `SEP_OFF_IRQ_STAT);
  wire hit_imask  = (avs_address == `SEP_OFF_IRQ_MASK);
  wire wr_ctrl    = wr_lane & hit_ctrl;
  wire wr_imask   = wr_lane & hit_imask;
  wire [3:0] clr_a = (wr_lane & hit_wa)    ? wd[3:0] : 4'h0;
  wire       clr_b = wr_lane & hit_wb & wd[0];
  wire [7:0] clr_f = (wr_lane & hit_fail)  ? wd[7:0] : 8'h00;
  wire [6:0] clr_s = (wr_lane & hit_safe)  ? wd[6:0] : 7'h00;
  wire [2:0] clr_i = (wr_lane & hit_istat) ? wd[2:0] : 3'h0;

  // Mode gating.
  wire in_init   = (op_mode == SEP_MODE_INIT);
  wire in_stop   = (op_mode == SEP_MODE_STOP);
  wire active    = (op_mode == SEP_MODE_NORMAL) | in_stop;
  wire stop_entry = in_stop & (mode_prev_reg != SEP_MODE_STOP);

  wire global    = ctrl_reg[`SEP_CTRL_GLOBAL];
  wire gpio_wake = ctrl_reg[`SEP_CTRL_GPIO_WAKE];

  // Wake events enabled as wake sources.
  wire [3:0] en_a;
  assign en_a[`SEP_WA_BUS_WAKE] = ctrl_reg[`SEP_CTRL_BUS_EN];
  assign en_a[`SEP_WA_BUS_TO]   = ~ctrl_reg[`SEP_CTRL_TO_MASK];
  assign en_a[`SEP_WA_HV_WAKE]  = ctrl_reg[`SEP_CTRL_HV_EN];
  assign en_a[`SEP_WA_TMR_WAKE] = ctrl_reg[`SEP_CTRL_TMR_EN];

  wire [3:0] set_a;
  assign set_a[`SEP_WA_BUS_WAKE] = ev_bus_wake;
  assign set_a[`SEP_WA_BUS_TO]   = bus_timeout_flag;
  assign set_a[`SEP_WA_HV_WAKE]  = ev_hv_wake;
  assign set_a[`SEP_WA_TMR_WAKE] = ev_timer_wake;
  // The GPIO counts only while it is configured as a wake input.
  wire set_b = ev_gpio_wake & gpio_wake;

  // Failures only interrupt in global class; safe errors never pulse the pin.
  wire pend_irq = |(pend_a_reg & en_a) | pend_b_reg
                | (global & (|pend_f_reg));
  wire wake_any = (|wake_a_reg) | wake_b_reg;
  wire start    = (state_reg == SEP_ST_IDLE) & active
                & (pend_irq | stop_req_reg);
  // Commit is taken on the same edge as the pin falls.
  wire commit   = start;

  // Pulse and gap timing share one counter.
  logic tmr_done;
  logic tmr_load;
  logic [`SEP_TMR_W-1:0] tmr_val;

  always_comb
  begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_val    = `SEP_TMR_W'(`SEP_PULSE_CYC);
    unique case (state_reg)
      SEP_ST_IDLE:
        if (start)
        begin
          state_next = SEP_ST_PULSE;
          tmr_load   = 1'b1;
        end
      SEP_ST_PULSE:
        // Leaving the active modes ends the pulse at once.
        if (tmr_done || !active)
        begin
          state_next = SEP_ST_GAP;
          tmr_load   = 1'b1;
          tmr_val    = `SEP_TMR_W'(`SEP_GAP_CYC);
        end
      SEP_ST_GAP:
        if (tmr_done)
          state_next = SEP_ST_IDLE;
      default:
        state_next = SEP_ST_IDLE;
    endcase
  end

  sep_timer #(.W(`SEP_TMR_W)) u_pulse_tmr
  (
    .clk      (clk),
    .resetn   (resetn),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // Hardware configuration select on the shared pin during init.
  logic pin_sync;
  logic filt_done;

  sep_sync u_pin_sync
  (
    .clk    (clk),
    .resetn (resetn),
    .pin    (irq_pin_in),
    .q      (pin_sync)
  );

  wire filt_load = (pin_sync != cfg_cand_reg) | ~in_init;

  sep_timer #(.W(`SEP_TMR_W)) u_cfg_filt
  (
    .clk      (clk),
    .resetn   (resetn),
    .load     (filt_load),
    .load_val (`SEP_TMR_W'(`SEP_CFG_FILT_CYC)),
    .done     (filt_done)
  );

  wire cfg_take = in_init & ~filt_load & filt_done;

  // Next values of the stored status; a set wins over a clear.
  wire [3:0] pend_a_next = (commit ? 4'h0 : pend_a_reg) | set_a;
  wire       pend_b_next = (commit ? 1'b0 : pend_b_reg) | set_b;
  wire [7:0] pend_f_next = (commit ? 8'h00 : pend_f_reg) | ev_fail;
  wire [3:0] wake_a_next = (wake_a_reg & ~clr_a)
                         | (commit ? pend_a_reg : 4'h0);
  wire       wake_b_next = (wake_b_reg & ~clr_b)
                         | (commit & pend_b_reg);
  wire [7:0] fail_next   = (fail_reg & ~clr_f)
                         | (commit ? pend_f_reg : 8'h00);
  // Restart and fail-safe errors are stored at once, never pulsed.
  wire [6:0] safe_next   = (safe_reg & ~clr_s) | ev_safe;
  wire stop_req_next = (stop_req_reg & ~commit)
                     | (stop_entry & wake_any);
  wire [2:0] istat_set = {|ev_safe, stop_entry & wake_any, commit};
  wire [2:0] istat_next = (irq_stat_reg & ~clr_i) | istat_set;

  // Read multiplexer; unmapped addresses read zero.
  wire [31:0] mode_word = {18'h0_0000, 1'b0, pend_irq, 2'h0, state_reg,
                           2'h0, cfg_valid_reg, hw_cfg_reg, 1'b0, op_mode};
  wire [31:0] rd_mux =
      hit_ctrl  ? {26'h0, ctrl_reg} :
      hit_wa    ? {28'h0, wake_a_reg} :
      hit_wb    ? {28'h0, wake_level_status, wake_b_reg} :
      hit_fail  ? {24'h0, fail_reg} :
      hit_safe  ? {25'h0, safe_reg} :
      hit_mode  ? mode_word :
      hit_istat ? {29'h0, irq_stat_reg} :
      hit_imask ? {29'h0, irq_mask_reg} : 32'h0000_0000;

  // Control and status registers.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_reg     <= `SEP_CTRL_RST;
      irq_mask_reg <= `SEP_IRQ_MASK_RST;
      wake_a_reg   <= 4'h0;
      wake_b_reg   <= 1'b0;
      fail_reg     <= 8'h00;
      safe_reg     <= 7'h00;
      irq_stat_reg <= 3'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= wd[5:0];
      if (wr_imask)
        irq_mask_reg <= wd[2:0];
      wake_a_reg   <= wake_a_next;
      wake_b_reg   <= wake_b_next;
      fail_reg     <= fail_next;
      safe_reg     <= safe_next;
      irq_stat_reg <= istat_next;
    end
  end

  // Pending events and pulser state.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg     <= SEP_ST_IDLE;
      pend_a_reg    <= 4'h0;
      pend_b_reg    <= 1'b0;
      pend_f_reg    <= 8'h00;
      stop_req_reg  <= 1'b0;
      mode_prev_reg <= SEP_MODE_INIT;
    end
    else
    begin
      state_reg     <= state_next;
      pend_a_reg    <= pend_a_next;
      pend_b_reg    <= pend_b_next;
      pend_f_reg    <= pend_f_next;
      stop_req_reg  <= stop_req_next;
      mode_prev_reg <= op_mode;
    end
  end

  // Pin drive. The pulser only observes the mode and has no path to
  // change it, so a pulse can never alter the operating mode.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_out_n_reg <= 1'b1;
      irq_oe_reg    <= 1'b0;
    end
    else
    begin
      irq_out_n_reg <= ~(state_next == SEP_ST_PULSE);
      // The pin is released in init so its strap level can be read.
      irq_oe_reg    <= ~in_init;
    end
  end

  // Configuration capture from the filtered pin.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_cand_reg  <= 1'b1; // Differs from the sync level, so loads filter.
      cfg_valid_reg <= 1'b0;
      hw_cfg_reg    <= 1'b0;
    end
    else
    begin
      cfg_cand_reg <= pin_sync;
      if (cfg_take)
      begin
        hw_cfg_reg    <= cfg_cand_reg;
        cfg_valid_reg <= 1'b1;
      end
    end
  end

  // Bus answer: one wait cycle, then the answer stands for one cycle.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_reg    <= 1'b1;
      rdata_reg   <= 32'h0000_0000;
      cpu_irq_reg <= 1'b0;
    end
    else
    begin
      wait_reg    <= ~(req & wait_reg);
      if (req & wait_reg)
        rdata_reg <= rd_mux;
      cpu_irq_reg <= |(istat_next & irq_mask_reg);
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq_out_n       = irq_out_n_reg;
  assign irq_oe          = irq_oe_reg;
  assign hw_cfg_sel      = hw_cfg_reg;
  assign cpu_irq         = cpu_irq_reg;
endmodule

// >>> sep_irq_props.sv
/*
  Port checker of the event interrupt pulser: pulse width, gap, mode gating,
  pin drive in init, config freeze and the register bus handshake.
  Assumes a bind onto the top module and the 40 MHz pulse counts.
*/
module sep_irq_props
  import sep_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic       avs_waitrequest,
  input  wire logic [2:0] op_mode,
  input  wire logic       irq_out_n,
  input  wire logic       irq_oe,
  input  wire logic       hw_cfg_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] low_cnt;
  logic [12:0] high_cnt;
  wire         run_mode = op_mode inside {SEP_MODE_NORMAL, SEP_MODE_STOP};
  wire         quiet_mode = op_mode inside {SEP_MODE_SLEEP,
                                             SEP_MODE_RESTART,
                                             SEP_MODE_FAILSAFE};
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      low_cnt <= 13'h0000;
    else
      low_cnt <= irq_out_n ? 13'h0000 : low_cnt + 13'h0001;
  // Saturates so that the first pulse after reset sees a full gap.
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      high_cnt <= 13'h1FFF;
    else if (!irq_out_n)
      high_cnt <= 13'h0000;
    else if (high_cnt != 13'h1FFF)
      high_cnt <= high_cnt + 13'h0001;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence ack_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence rise_s;
    $rose(irq_out_n) && $past(run_mode);
  endsequence
  pulse_width_a: assert property (rise_s |-> low_cnt inside {[4000:4001]})
    else $error("pulse width wrong");
  pulse_max_a: assert property (!irq_out_n |-> low_cnt <= 13'd4000)
    else $error("pulse too long");
  pulse_gap_a: assert property ($fell(irq_out_n) |-> high_cnt >= 13'd4000)
    else $error("gap too short");
  mode_gate_a: assert property ($fell(irq_out_n) |-> $past(run_mode))
    else $error("pulse outside normal or stop");
  quiet_mode_a: assert property (quiet_mode && $past(quiet_mode) |-> irq_out_n)
    else $error("pin active in quiet mode");
  drive_en_a: assert property (1'b1 |=> irq_oe == ($past(op_mode) != 3'h0))
    else $error("pin drive wrong");
  cfg_freeze_a: assert property (op_mode != 3'h0 && $past(op_mode) != 3'h0
    |=> $stable(hw_cfg_sel))
    else $error("config moved outside init");
  bus_ack_a: assert property (req_s |=> ack_s)
    else $error("bus answer wrong");
  bus_idle_a: assert property (!(avs_read || avs_write) && avs_waitrequest
    |=> avs_waitrequest)
    else $error("spurious bus answer");
endmodule

bind sep_event_interrupt_pulser sep_irq_props u_props
(
  .clk             (clk),
  .resetn          (resetn),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_waitrequest (avs_waitrequest),
  .op_mode         (op_mode),
  .irq_out_n       (irq_out_n),
  .irq_oe          (irq_oe),
  .hw_cfg_sel      (hw_cfg_sel)
);

// >>> sep_host_model.sv
/*
  Host interrupt input: resolves the pin and counts falling edges.
  Assumes the strap level stands in for the pin when the device lets go.
*/
module sep_host_model
(
  input  wire logic        clk,
  input  wire logic        irq_out_n,
  input  wire logic        irq_oe,
  input  wire logic        cfg_lvl,
  output logic             irq_pin_in,
  output logic [15:0]      pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin_q = 1'b1;
  assign irq_pin_in = irq_oe ? irq_out_n : cfg_lvl;
  initial pulses = 16'h0000;
  always @(posedge clk)
  begin
    pin_q <= irq_pin_in;
    if (pin_q && !irq_pin_in)
      pulses <= pulses + 16'h0001;
  end
endmodule

// >>> sep_event_interrupt_pulser_test.sv
/*
  Self-checking bench of the event interrupt pulser over Avalon-MM.
  Assumes the host model on the pin and the checker bound to the top.
*/
`define CHK(a, e) \
  begin \
    num_checks++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module sep_event_interrupt_pulser_test
  import sep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  op_mode = 3'h0;
  logic [4:0]  ev_w = 5'h00;
  logic [7:0]  ev_f = 8'h00;
  logic [6:0]  ev_s = 7'h00;
  logic        irq_out_n, irq_oe, hw_cfg_sel, cpu_irq, irq_pin_in;
  logic        cfg_lvl = 1'b1;
  logic [15:0] pulses;
  logic [15:0] exp_p = 16'h0000;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #12.5 clk = ~clk;
  sep_event_interrupt_pulser dut
  (
    .clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .op_mode(op_mode), .ev_bus_wake(ev_w[0]), .bus_timeout_flag(ev_w[1]),
    .ev_hv_wake(ev_w[2]), .ev_timer_wake(ev_w[3]), .ev_gpio_wake(ev_w[4]),
    .ev_fail(ev_f), .ev_safe(ev_s), .wake_level_status(3'h5),
    .irq_pin_in(irq_pin_in), .irq_out_n(irq_out_n), .irq_oe(irq_oe),
    .hw_cfg_sel(hw_cfg_sel), .cpu_irq(cpu_irq)
  );
  sep_host_model u_host
  (
    .clk(clk), .irq_out_n(irq_out_n), .irq_oe(irq_oe), .cfg_lvl(cfg_lvl),
    .irq_pin_in(irq_pin_in), .pulses(pulses)
  );
  task wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    `CHK(avs_readdata, e)
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task fire(input logic [4:0] w, input logic [7:0] f, input logic [6:0] s);
    ev_w <= w;
    ev_f <= f;
    ev_s <= s;
    @(posedge clk);
    ev_w <= 5'h00;
    ev_f <= 8'h00;
    ev_s <= 7'h00;
    @(posedge clk);
  endtask
  // Waits out one pulse and its gap before the count is compared.
  task chk_p(input logic [15:0] add);
    repeat (8400) @(posedge clk);
    exp_p = exp_p + add;
    `CHK(pulses, exp_p)
  endtask
  task results;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'h0000_000E);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(8'h08, 32'h0000_000A);
    repeat (600) @(posedge clk);
    `CHK(hw_cfg_sel, 1'b1)
    rd(8'h14, 32'h0000_0030);
    op_mode <= SEP_MODE_NORMAL;
    fire(5'h04, 8'h00, 7'h00);
    repeat (100) @(posedge clk);
    `CHK(irq_out_n, 1'b0)
    fire(5'h08, 8'h00, 7'h00);
    chk_p(16'h0002);
    repeat (8400) @(posedge clk);
    rd(8'h04, 32'h0000_000C);
    rd(8'h18, 32'h0000_0001);
    `CHK(cpu_irq, 1'b0)
    wr(8'h1C, 32'h0000_0001);
    // The level output follows the new mask one edge after the write.
    @(posedge clk);
    `CHK(cpu_irq, 1'b1)
    wr(8'h18, 32'h0000_0001);
    @(posedge clk);
    `CHK(cpu_irq, 1'b0)
    wr(8'h04, 32'h0000_000F);
    rd(8'h04, 32'h0000_0000);
    wr(8'h00, 32'h0000_000D);
    fire(5'h00, 8'h01, 7'h00);
    chk_p(16'h0001);
    rd(8'h0C, 32'h0000_0001);
    wr(8'h0C, 32'h0000_0001);
    wr(8'h00, 32'h0000_000C);
    fire(5'h02, 8'h00, 7'h00);
    chk_p(16'h0001);
    rd(8'h04, 32'h0000_0002);
    wr(8'h00, 32'h0000_0028);
    fire(5'h17, 8'h02, 7'h01);
    chk_p(16'h0000);
    rd(8'h10, 32'h0000_0001);
    op_mode <= SEP_MODE_SLEEP;
    fire(5'h08, 8'h00, 7'h00);
    chk_p(16'h0000);
    op_mode <= SEP_MODE_NORMAL;
    chk_p(16'h0001);
    op_mode <= SEP_MODE_STOP;
    chk_p(16'h0001);
    rd(8'h18, 32'h0000_0007);
    wr(8'h00, 32'h0000_0010);
    fire(5'h10, 8'h00, 7'h00);
    chk_p(16'h0001);
    rd(8'h08, 32'h0000_000B);
    results();
  end
endmodule
